/* sim/ptf_host_model.sv */
// Purpose: Host side model driving the register port and the stop command
// Assumes: Requests launched on the falling edge, one request per call
// Notes:   Write data is inverted once released so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Host model
module ptf_host_model (
  // Clock
  input  wire logic                       clk_i,
  // Register port
  output var  logic                       reg_wr_o,
  output var  logic                       reg_rd_o,
  output var  logic [ptf_pkg::ADDR_W-1:0] reg_addr_o,
  output var  logic [ptf_pkg::DATA_W-1:0] reg_wdata_o,
  // Command decoder side
  output var  logic                       stop_cmd_o
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    stop_cmd_o  = 1'b0;
  end

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~d;
  endtask : write

  task automatic read(input logic [7:0] a);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge clk_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
  endtask : read

  // Only issued after the busy flag was seen set
  task automatic stop();
    @(negedge clk_i);
    stop_cmd_o = 1'b1;
    @(negedge clk_i);
    stop_cmd_o = 1'b0;
  endtask : stop
endmodule : ptf_host_model
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the pattern 3 parameter and status bank
// Assumes: Inputs driven on the falling edge, reads checked from a queue
// Notes:   Async status inputs get six cycles to pass the synchroniser
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Bench
module tb_top;
  logic                 clk_i;
  logic                 rst_n_i;
  logic                 reg_wr_i;
  logic                 reg_rd_i;
  logic [7:0]           reg_addr_i;
  logic [7:0]           reg_wdata_i;
  logic [7:0]           reg_rdata_o;
  logic                 reg_rvalid_o;
  ptf_pkg::ptf_engine_t engine_i;
  logic                 stop_cmd_i;
  logic                 thermal_shutdown_i;
  logic                 power_on_reset_i;
  ptf_pkg::ptf_cfg_t    cfg_o;
  ptf_pkg::ptf_dur_t    dur_o;
  ptf_pkg::ptf_flags_t  flags_o;
  int                   fail_count;
  int                   check_count;
  logic [7:0]           exp_q[$];
  logic [15:0]          lfsr_r;
  logic [7:0]           d3;
  logic [7:0]           d4;
  logic [3:0]           c;

  ptf_host_model host_u (.clk_i(clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .stop_cmd_o(stop_cmd_i));

  ptf_regs dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .engine_i(engine_i), .stop_cmd_i(stop_cmd_i),
    .thermal_shutdown_i(thermal_shutdown_i), .power_on_reset_i(power_on_reset_i),
    .cfg_o(cfg_o), .dur_o(dur_o), .flags_o(flags_o));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic [15:0] dur_ms(input logic [3:0] k);
    case (k)
      4'hB:    return 16'(ptf_pkg::MS_1S);
      4'hC:    return 16'(ptf_pkg::MS_2S);
      4'hD:    return 16'(ptf_pkg::MS_4S);
      4'hE:    return 16'(ptf_pkg::MS_6S);
      4'hF:    return 16'(ptf_pkg::MS_8S);
      default: return 16'(ptf_pkg::STEP_MS) * {12'h000, k};
    endcase
  endfunction : dur_ms

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.read(a);
  endtask : rd

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wait_n

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // Read results are matched in issue order
  always @(negedge clk_i) begin
    if (reg_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) chk("rdata_extra", 16'h0001, 16'h0000);
      else chk("rdata", {8'h00, reg_rdata_o}, {8'h00, exp_q.pop_front()});
    end
  end

  initial begin
    #4000000;
    fail_count++;
    print_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    fail_count = 0;
    check_count = 0;
    lfsr_r = 16'h2654;
    rst_n_i = 1'b0;
    engine_i = '0;
    thermal_shutdown_i = 1'b0;
    power_on_reset_i = 1'b0;
    wait_n(8);
    rst_n_i = 1'b1;
    wait_n(6);
    rd(ptf_pkg::ADDR_POINT3, 8'h00);
    rd(ptf_pkg::ADDR_POINT4, 8'h00);
    rd(ptf_pkg::ADDR_RAMP_A, 8'h00);
    rd(ptf_pkg::ADDR_RAMP_B, 8'h00);
    rd(ptf_pkg::ADDR_FLAGS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      d3 = (i == 0) ? 8'hFF : lfsr_r[7:0];
      d4 = (i == 0) ? 8'h80 : lfsr_r[15:8];
      host_u.write(ptf_pkg::ADDR_POINT3, d3);
      host_u.write(ptf_pkg::ADDR_POINT4, d4);
      chk("point3", {8'h00, cfg_o.point3}, {8'h00, d3});
      chk("point4", {8'h00, cfg_o.point4}, {8'h00, d4});
      rd(ptf_pkg::ADDR_POINT3, d3);
      rd(ptf_pkg::ADDR_POINT4, d4);
    end
    for (int k = 0; k < 16; k++) begin
      c = k[3:0];
      host_u.write(ptf_pkg::ADDR_RAMP_A, {~c, c});
      host_u.write(ptf_pkg::ADDR_RAMP_B, {c, ~c});
      wait_n(1);
      chk("dur0", {3'h0, dur_o[0]}, dur_ms(c));
      chk("dur1", {3'h0, dur_o[1]}, dur_ms(~c));
      chk("dur2", {3'h0, dur_o[2]}, dur_ms(~c));
      chk("dur3", {3'h0, dur_o[3]}, dur_ms(c));
      rd(ptf_pkg::ADDR_RAMP_A, {~c, c});
      rd(ptf_pkg::ADDR_RAMP_B, {c, ~c});
    end
    for (int i = 0; i < 6; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      engine_i = (i == 0) ? 8'h00 : lfsr_r[7:0];
      wait_n(2);
      rd(ptf_pkg::ADDR_FLAGS, {1'b0, engine_i.out_busy, |engine_i.eng_run, 2'b00});
    end
    engine_i = 8'h00;
    thermal_shutdown_i = 1'b1;
    wait_n(6);
    rd(ptf_pkg::ADDR_FLAGS, 8'h02);
    thermal_shutdown_i = 1'b0;
    power_on_reset_i = 1'b1;
    wait_n(6);
    rd(ptf_pkg::ADDR_FLAGS, 8'h01);
    host_u.write(ptf_pkg::ADDR_FLAGS, 8'hFE);
    rd(ptf_pkg::ADDR_FLAGS, 8'h01);
    rd(ptf_pkg::ADDR_FLAGS, 8'h01);
    rd(8'h41, 8'h00);
    power_on_reset_i = 1'b0;
    engine_i = 8'h11;
    wait_n(6);
    rd(ptf_pkg::ADDR_FLAGS, 8'h0C);
    host_u.stop();
    chk("busy_stop", {15'h0000, flags_o.eng_busy}, 16'h0000);
    rd(ptf_pkg::ADDR_FLAGS, 8'h08);
    engine_i = 8'h00;
    wait_n(2);
    engine_i = 8'h82;
    wait_n(2);
    chk("busy_again", {8'h00, flags_o}, 16'h0044);
    // Reset in mid-run must drop every stored field and flag
    rst_n_i = 1'b0;
    wait_n(3);
    chk("pts_rst", cfg_o[31:16], 16'h0000);
    chk("ramps_rst", cfg_o[15:0], 16'h0000);
    chk("flags_rst", {8'h00, flags_o}, 16'h0000);
    engine_i = 8'h00;
    rst_n_i = 1'b1;
    rd(ptf_pkg::ADDR_POINT4, 8'h00);
    rd(ptf_pkg::ADDR_RAMP_B, 8'h00);
    for (int i = 0; i < 8 && exp_q.size() != 0; i++) wait_n(1);
    if (exp_q.size() != 0) fail_count++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

/* verilog/ptf_pkg.sv */
// Purpose: Shared constants and carriers for the pattern 3 parameter and status register bank
// Assumes: 8-bit register port with 8-bit addresses, driven by the serial bus front end
// Notes:   Ramp duration codes decode to milliseconds
`default_nettype none
// ============================================================================
// Package
package ptf_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned NIB_W    = 4;
  localparam int unsigned N_RAMP   = 4;
  localparam int unsigned N_ENG    = 4;
  localparam int unsigned DUR_W    = 13;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_POINT3 = 8'h3C;
  localparam logic [7:0] ADDR_POINT4 = 8'h3D;
  localparam logic [7:0] ADDR_RAMP_A = 8'h3E;
  localparam logic [7:0] ADDR_RAMP_B = 8'h3F;
  localparam logic [7:0] ADDR_FLAGS  = 8'h40;

  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [3:0] RAMP_RESET  = 4'h0;
  localparam logic [7:0] READ_NONE   = 8'h00;

  // ==========================================================================
  // Ramp duration code
  localparam logic [3:0]       CODE_LIN_MAX = 4'hA;
  localparam logic [3:0]       CODE_1S      = 4'hB;
  localparam logic [3:0]       CODE_2S      = 4'hC;
  localparam logic [3:0]       CODE_4S      = 4'hD;
  localparam logic [3:0]       CODE_6S      = 4'hE;
  localparam logic [3:0]       CODE_8S      = 4'hF;
  localparam logic [DUR_W-1:0] STEP_MS      = 13'h0032;
  localparam logic [DUR_W-1:0] MS_1S        = 13'h03E8;
  localparam logic [DUR_W-1:0] MS_2S        = 13'h07D0;
  localparam logic [DUR_W-1:0] MS_4S        = 13'h0FA0;
  localparam logic [DUR_W-1:0] MS_6S        = 13'h1770;
  localparam logic [DUR_W-1:0] MS_8S        = 13'h1F40;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0]              point3;
    logic [7:0]              point4;
    logic [N_RAMP-1:0][3:0]  ramp;
  } ptf_cfg_t;

  localparam ptf_cfg_t CFG_RESET = '{point3: LEVEL_RESET, point4: LEVEL_RESET,
                                     ramp: {N_RAMP{RAMP_RESET}}};

  typedef logic [N_RAMP-1:0][DUR_W-1:0] ptf_dur_t;

  typedef struct packed {
    logic [N_ENG-1:0] out_busy;
    logic [N_ENG-1:0] eng_run;
  } ptf_engine_t;

  // Bit layout of the status register, bit 7 down to bit 0
  typedef struct packed {
    logic             rsvd;
    logic [N_ENG-1:0] out_busy;
    logic             eng_busy;
    logic             thermal_shutdown_flag;
    logic             por;
  } ptf_flags_t;

  localparam ptf_flags_t FLAGS_RESET = '0;

endpackage : ptf_pkg

`default_nettype wire

/* verilog/ptf_regs.sv */
// Purpose: Pattern 3 level points, ramp times and the device status register
// Assumes: Register port strobes are one-cycle pulses on clk_i
// Notes:   Thermal and power-on inputs are asynchronous and are resynchronised
`timescale 1ns/1ps
`default_nettype none

module ptf_regs (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // Register port
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  input  wire logic [ptf_pkg::ADDR_W-1:0]  reg_addr_i,
  input  wire logic [ptf_pkg::DATA_W-1:0]  reg_wdata_i,
  output logic      [ptf_pkg::DATA_W-1:0]  reg_rdata_o,
  output logic                             reg_rvalid_o,
  // Engine sequencer, stop command and analog status
  input  wire ptf_pkg::ptf_engine_t        engine_i,
  input  wire logic                        stop_cmd_i,
  input  wire logic                        thermal_shutdown_i,
  input  wire logic                        power_on_reset_i,
  // Stored pattern fields, decoded durations and status flags
  output ptf_pkg::ptf_cfg_t                cfg_o,
  output ptf_pkg::ptf_dur_t                dur_o,
  output ptf_pkg::ptf_flags_t              flags_o
);

  // ==========================================================================
  // Duration decode
  function automatic logic [ptf_pkg::DUR_W-1:0] dur_ms(input logic [3:0] code);
    logic [ptf_pkg::DUR_W-1:0] ms;
    ms = '0;
    if (code <= ptf_pkg::CODE_LIN_MAX) begin
      ms = ptf_pkg::DUR_W'(code * ptf_pkg::STEP_MS);
    end else begin
      case (code)
        ptf_pkg::CODE_1S: ms = ptf_pkg::MS_1S;
        ptf_pkg::CODE_2S: ms = ptf_pkg::MS_2S;
        // Lost codes kept in line with the common encoding
        ptf_pkg::CODE_4S: ms = ptf_pkg::MS_4S;
        ptf_pkg::CODE_6S: ms = ptf_pkg::MS_6S;
        ptf_pkg::CODE_8S: ms = ptf_pkg::MS_8S;
        default:          ms = '0;
      endcase
    end
    return ms;
  endfunction : dur_ms

  // ==========================================================================
  // Configuration registers
  ptf_pkg::ptf_cfg_t cfg_r;
  ptf_pkg::ptf_cfg_t cfg_nxt;

  always_comb begin
    cfg_nxt = cfg_r;
    if (reg_wr_i) begin
      case (reg_addr_i)
        ptf_pkg::ADDR_POINT3: cfg_nxt.point3 = reg_wdata_i;
        ptf_pkg::ADDR_POINT4: cfg_nxt.point4 = reg_wdata_i;
        ptf_pkg::ADDR_RAMP_A: begin
          cfg_nxt.ramp[0] = reg_wdata_i[ptf_pkg::NIB_W-1:0];
          cfg_nxt.ramp[1] = reg_wdata_i[ptf_pkg::DATA_W-1:ptf_pkg::NIB_W];
        end
        ptf_pkg::ADDR_RAMP_B: begin
          cfg_nxt.ramp[2] = reg_wdata_i[ptf_pkg::NIB_W-1:0];
          cfg_nxt.ramp[3] = reg_wdata_i[ptf_pkg::DATA_W-1:ptf_pkg::NIB_W];
        end
        // Status and unmapped writes fall through untouched
        default: cfg_nxt = cfg_r;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_r <= ptf_pkg::CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign cfg_o = cfg_r;

  // ==========================================================================
  // Decoded durations, one cycle behind the stored codes
  ptf_pkg::ptf_dur_t dur_r;
  ptf_pkg::ptf_dur_t dur_nxt;

  always_comb begin
    dur_nxt = dur_r;
    for (int i = 0; i < ptf_pkg::N_RAMP; i++) begin
      dur_nxt[i] = dur_ms(cfg_r.ramp[i]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dur_r <= '0;
    end else begin
      dur_r <= dur_nxt;
    end
  end

  assign dur_o = dur_r;

  // ==========================================================================
  // Asynchronous status synchronisers
  // A change is accepted only when stages two and three agree, so a
  // glitch shorter than a clock never reaches the status register.
  logic [2:0] tsd_sync_r;
  logic [2:0] tsd_sync_nxt;
  logic [2:0] por_sync_r;
  logic [2:0] por_sync_nxt;

  always_comb begin
    tsd_sync_nxt = {tsd_sync_r[1:0], thermal_shutdown_i};
    por_sync_nxt = {por_sync_r[1:0], power_on_reset_i};
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tsd_sync_r <= '0;
      por_sync_r <= '0;
    end else begin
      tsd_sync_r <= tsd_sync_nxt;
      por_sync_r <= por_sync_nxt;
    end
  end

  // ==========================================================================
  // Status register
  ptf_pkg::ptf_flags_t flags_r;
  ptf_pkg::ptf_flags_t flags_nxt;
  logic                stopping_r;
  logic                stopping_nxt;

  always_comb begin
    flags_nxt = flags_r;
    // Busy is held low after a stop until every engine has gone idle,
    // so a sequencer that lags a cycle cannot set it again.
    stopping_nxt = (stopping_r | stop_cmd_i) & (|engine_i.eng_run);
    flags_nxt.rsvd     = 1'h0;
    flags_nxt.out_busy = engine_i.out_busy;
    flags_nxt.eng_busy = (|engine_i.eng_run) & ~stopping_r & ~stop_cmd_i;
    if (tsd_sync_r[1] == tsd_sync_r[2]) begin
      flags_nxt.thermal_shutdown_flag = tsd_sync_r[2];
    end
    if (por_sync_r[1] == por_sync_r[2]) begin
      flags_nxt.por = por_sync_r[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flags_r    <= ptf_pkg::FLAGS_RESET;
      stopping_r <= 1'h0;
    end else begin
      flags_r    <= flags_nxt;
      stopping_r <= stopping_nxt;
    end
  end

  assign flags_o = flags_r;

  // ==========================================================================
  // Read path
  logic [ptf_pkg::DATA_W-1:0] rdata_r;
  logic [ptf_pkg::DATA_W-1:0] rdata_nxt;
  logic                       rvalid_r;
  logic                       rvalid_nxt;

  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = reg_rd_i;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ptf_pkg::ADDR_POINT3: rdata_nxt = cfg_r.point3;
        ptf_pkg::ADDR_POINT4: rdata_nxt = cfg_r.point4;
        ptf_pkg::ADDR_RAMP_A: rdata_nxt = {cfg_r.ramp[1], cfg_r.ramp[0]};
        ptf_pkg::ADDR_RAMP_B: rdata_nxt = {cfg_r.ramp[3], cfg_r.ramp[2]};
        // Reading has no side effect on any flag
        ptf_pkg::ADDR_FLAGS:  rdata_nxt = flags_r;
        default:              rdata_nxt = ptf_pkg::READ_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_r  <= ptf_pkg::READ_NONE;
      rvalid_r <= 1'h0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata_o  = rdata_r;
  assign reg_rvalid_o = rvalid_r;

  // ==========================================================================
  // Assertions
  sequence s_wr(logic [7:0] addr);
    reg_wr_i && reg_addr_i == addr;
  endsequence

  property p_out_busy(int unsigned idx);
    @(posedge clk_i) disable iff (!rst_n_i)
      $past(rst_n_i) |-> flags_r.out_busy[idx] == $past(engine_i.out_busy[idx]);
  endproperty

  a_point3_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wr(ptf_pkg::ADDR_POINT3) |=> cfg_o.point3 == $past(reg_wdata_i))
    else $error("point three level not stored");

  a_point4_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wr(ptf_pkg::ADDR_POINT4) |=> cfg_o.point4 == $past(reg_wdata_i))
    else $error("point four level not stored");

  a_ramp_a_split: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wr(ptf_pkg::ADDR_RAMP_A) |=> {cfg_o.ramp[1], cfg_o.ramp[0]} == $past(reg_wdata_i))
    else $error("ramp register A nibbles misplaced");

  a_ramp1_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wr(ptf_pkg::ADDR_RAMP_B) |=> $stable(cfg_o.ramp[1]))
    else $error("second ramp changed by register B write");

  a_ramp_b_split: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wr(ptf_pkg::ADDR_RAMP_B) |=> {cfg_o.ramp[3], cfg_o.ramp[2]} == $past(reg_wdata_i))
    else $error("ramp register B nibbles misplaced");

  a_ramp_b_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == ptf_pkg::ADDR_RAMP_B && !reg_wr_i
      |=> reg_rvalid_o && reg_rdata_o[ptf_pkg::DATA_W-1:ptf_pkg::NIB_W] == cfg_o.ramp[3])
    else $error("fourth ramp reads back wrong");

  a_out0_busy: assert property (p_out_busy(0))
    else $error("output 0 busy flag wrong");

  a_out1_busy: assert property (p_out_busy(1))
    else $error("output 1 busy flag wrong");

  a_out2_busy: assert property (p_out_busy(2))
    else $error("output 2 busy flag wrong");

  a_out3_busy: assert property (p_out_busy(3))
    else $error("output 3 busy flag wrong");

  a_rsvd_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !flags_o.rsvd)
    else $error("reserved status bit set");

  a_busy_any: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && !$past(stopping_r) && !$past(stop_cmd_i)
      |-> flags_o.eng_busy == $past(|engine_i.eng_run))
    else $error("global busy does not follow engines");

  a_tsd_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tsd_sync_r[1] == tsd_sync_r[2] |=> flags_o.thermal_shutdown_flag == $past(tsd_sync_r[2]))
    else $error("thermal flag does not follow input");

  a_por_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    por_sync_r[1] == por_sync_r[2] |=> flags_o.por == $past(por_sync_r[2]))
    else $error("power-on flag does not follow input");

  a_stop_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    stop_cmd_i |=> !flags_o.eng_busy)
    else $error("stop did not clear busy flag");

  a_flags_no_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wr(ptf_pkg::ADDR_FLAGS) |=> $stable(cfg_o))
    else $error("status write altered configuration");

  a_code_d_four: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_o.ramp[0] == ptf_pkg::CODE_4S ##1 $past(rst_n_i) |-> dur_o[0] == ptf_pkg::MS_4S)
    else $error("code D not four seconds");

  a_code_e_six: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_o.ramp[2] == ptf_pkg::CODE_6S |=> dur_o[2] == ptf_pkg::MS_6S)
    else $error("code E not six seconds");

endmodule : ptf_regs

`default_nettype wire
